// File: hdl/ccr_quadrant.sv
// One quadrant: vertical register, horizontal register, sense and switch.
`include "ccr_cfg.svh"
`default_nettype none

module ccr_quadrant
(
	input  wire logic                               clk_i,
	input  wire logic                               srst_i,
	input  wire logic                               vertical_phase1_top_i,
	input  wire logic                               vertical_phase1_bottom_i,
	input  wire logic                               row_transfer_i,
	input  wire logic                               horiz_last_gate_i,
	input  wire logic                               normal_path_switch_i,
	input  wire logic                               multiplier_path_switch_i,
	input  wire logic [`CCR_NCOLS-1:0][`CCR_CW-1:0] photodiode_charge_i,
	output var  logic [`CCR_CW-1:0]                 threshold_sense_output_o,
	output var  logic                               sense_valid_o,
	output var  logic [`CCR_CW-1:0]                 low_gain_output_o,
	output var  logic                               low_gain_valid_o,
	output var  logic [`CCR_CW-1:0]                 multiplier_output_o,
	output var  logic                               multiplier_valid_o
);

	// ------------------------------------------------------------------
	// Pin synchronisation.
	// ------------------------------------------------------------------
	logic [`CCR_NSYNC-1:0] pins;
	logic [`CCR_NSYNC-1:0] syn;

	assign pins = {multiplier_path_switch_i, normal_path_switch_i,
		horiz_last_gate_i, row_transfer_i,
		vertical_phase1_bottom_i, vertical_phase1_top_i};

	ccr_sync u_sync
	(
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.pins_i (pins),
		.sync_o (syn)
	);

	logic pd_lvl;
	logic row_lvl;
	logic last_lvl;
	logic nsw_lvl;
	logic msw_lvl;

	assign pd_lvl   = syn[0] & syn[1];
	assign row_lvl  = syn[2];
	assign last_lvl = syn[3];
	assign nsw_lvl  = syn[4];
	assign msw_lvl  = syn[5];

	// ------------------------------------------------------------------
	// Charge arithmetic.
	// ------------------------------------------------------------------
	function automatic logic [`CCR_CW-1:0] sat_add
	(
		input logic [`CCR_CW-1:0] a,
		input logic [`CCR_CW-1:0] b
	);
		logic [`CCR_CW:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = s[`CCR_CW] ? `CCR_SAT : s[`CCR_CW-1:0];
	endfunction

	// ------------------------------------------------------------------
	// State.
	// ------------------------------------------------------------------
	ccr_pkg::ccr_state_t st;
	ccr_pkg::ccr_state_t next_st;

	logic pd_edge;
	logic row_edge;
	logic shift;

	assign pd_edge  = pd_lvl & ~st.pd_prev;
	assign row_edge = row_lvl & ~st.row_prev;
	assign shift    = ~last_lvl & st.last_prev;

	always_comb
	begin
		next_st           = st;
		next_st.pd_prev   = pd_lvl;
		next_st.row_prev  = row_lvl;
		next_st.last_prev = last_lvl;
		next_st.sense_v   = 1'b0;
		next_st.low_v     = 1'b0;
		next_st.mult_v    = 1'b0;
		// Photodiode charge is added to what the column already holds.
		if (pd_edge)
		begin
			for (int c = 0; c < `CCR_NCOLS; c++)
			begin
				next_st.vreg[c] = sat_add(st.vreg[c],
					photodiode_charge_i[c]);
			end
		end
		if (row_edge)
		begin
			// Prescan and dark cells ahead of the active packets.
			next_st.hreg = '0;
			for (int c = 0; c < `CCR_NCOLS; c++)
			begin
				next_st.hreg[`CCR_ACTIVE_POS + c] = st.vreg[c];
			end
			if (!pd_edge)
			begin
				next_st.vreg = '0;
			end
			else
			begin
				next_st.vreg = photodiode_charge_i;
			end
		end
		else if (shift)
		begin
			// One pixel per complete cycle, nearest packet to the gate.
			for (int i = 0; i < `CCR_HREG_LEN - 1; i++)
			begin
				next_st.hreg[i] = st.hreg[i + 1];
			end
			next_st.hreg[`CCR_HREG_LEN-1] = '0;
			next_st.fg      = st.hreg[0];
			next_st.sense   = st.hreg[0];
			next_st.sense_v = 1'b1;
			// Sensing leaves the packet intact for the switch path.
			for (int i = 0; i < `CCR_PIPE_LEN - 1; i++)
			begin
				next_st.pipe[i] = st.pipe[i + 1];
			end
			next_st.pipe[`CCR_PIPE_LEN-1] = st.fg;
			// The packet leaving the path goes where the switch pulsed.
			if (st.msw_seen && !st.nsw_seen)
			begin
				next_st.mult_q = st.pipe[0];
				next_st.mult_v = 1'b1;
			end
			else if (st.nsw_seen && !st.msw_seen)
			begin
				next_st.low_q = st.pipe[0];
				next_st.low_v = 1'b1;
			end
			next_st.nsw_seen = nsw_lvl;
			next_st.msw_seen = msw_lvl;
		end
		if (!shift)
		begin
			next_st.nsw_seen = st.nsw_seen | nsw_lvl;
			next_st.msw_seen = st.msw_seen | msw_lvl;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign threshold_sense_output_o = st.sense;
	assign sense_valid_o            = st.sense_v;
	assign low_gain_output_o        = st.low_q;
	assign low_gain_valid_o         = st.low_v;
	assign multiplier_output_o      = st.mult_q;
	assign multiplier_valid_o       = st.mult_v;

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	sequence s_fall;
		st.last_prev && !last_lvl;
	endsequence

	sequence s_pd_only;
		pd_edge && !row_edge;
	endsequence

	vreg_adds_a: assert property (@(posedge clk_i) disable iff (srst_i)
		s_pd_only |=> st.vreg[0] == sat_add($past(st.vreg[0]),
			$past(photodiode_charge_i[0])))
		else $error("vertical register did not add charge");

	one_pixel_a: assert property (@(posedge clk_i) disable iff (srst_i)
		s_fall ##0 !row_edge |=> st.hreg[0] == $past(st.hreg[1])
			&& st.hreg[`CCR_HREG_LEN-2] == $past(st.hreg[`CCR_HREG_LEN-1]))
		else $error("horizontal register did not advance one pixel");

	row_layout_a: assert property (@(posedge clk_i) disable iff (srst_i)
		row_edge |=> st.hreg[`CCR_DARK_POS] == '0
			&& st.hreg[`CCR_ACTIVE_POS] == $past(st.vreg[0])
			&& st.hreg[`CCR_ACTIVE_POS-1] == '0)
		else $error("row not placed 12 and 36 cycles from the gate");

	fg_on_fall_a: assert property (@(posedge clk_i) disable iff (srst_i)
		s_fall ##0 !row_edge |=> sense_valid_o
			&& threshold_sense_output_o == $past(st.hreg[0]))
		else $error("packet not sensed on last gate fall");

	sense_intact_a: assert property (@(posedge clk_i) disable iff (srst_i)
		s_fall ##0 !row_edge |=> st.pipe[`CCR_PIPE_LEN-1] == $past(st.fg))
		else $error("sensed packet changed on its way downstream");

	no_spurious_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!(st.last_prev && !last_lvl) |=> !sense_valid_o && !low_gain_valid_o
			&& !multiplier_valid_o)
		else $error("output pulse without a horizontal cycle");

	route_excl_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(low_gain_valid_o || multiplier_valid_o) |->
			!(low_gain_valid_o && multiplier_valid_o)
			&& $past(st.nsw_seen) != $past(st.msw_seen))
		else $error("packet sent to both outputs or with no route");

	route_delay_a: assert property (@(posedge clk_i) disable iff (srst_i)
		multiplier_valid_o |-> multiplier_output_o == $past(st.pipe[0]))
		else $error("multiplier packet not taken from path end");

	low_route_a: assert property (@(posedge clk_i) disable iff (srst_i)
		low_gain_valid_o |-> low_gain_output_o == $past(st.pipe[0])
			&& $past(st.nsw_seen))
		else $error("low gain packet not taken from path end");

endmodule

`default_nettype wire

// File: hdl/ccr_cfg.svh
// Constants of the quadrant charge routing model.
// Operation
// - Diode charge moved into a non-empty vertical register adds to it.
// - Each complementary horizontal cycle moves every packet one pixel, unless its last gate fall meets a row transfer edge.
// - Dark pixel reaches sense after 12 cycles, first active 24 later.
// - Packet moves under the floating gate as the last gate falls.
// - Threshold sensing leaves the packet's electron count unchanged.
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

`define CCR_CW           16
`define CCR_NCOLS        8
`define CCR_DARK_POS     11
`define CCR_ACTIVE_POS   35
`define CCR_HREG_LEN     43
`define CCR_SWITCH_DELAY 28
`define CCR_PIPE_LEN     27
`define CCR_NSYNC        6
`define CCR_SAT          16'hFFFF

`endif

// File: hdl/ccr_pkg.sv
// Types of the quadrant charge routing model.
`include "ccr_cfg.svh"
`default_nettype none

package ccr_pkg;

	typedef logic [`CCR_CW-1:0] ccr_charge_t;

	typedef struct packed
	{
		logic [`CCR_NSYNC-1:0] s1;
		logic [`CCR_NSYNC-1:0] s2;
	} ccr_sync_t;

	typedef struct packed
	{
		logic [`CCR_NCOLS-1:0][`CCR_CW-1:0]    vreg;
		logic [`CCR_HREG_LEN-1:0][`CCR_CW-1:0] hreg;
		logic [`CCR_PIPE_LEN-1:0][`CCR_CW-1:0] pipe;
		logic [`CCR_CW-1:0]                    fg;
		logic                                  pd_prev;
		logic                                  row_prev;
		logic                                  last_prev;
		logic                                  nsw_seen;
		logic                                  msw_seen;
		logic [`CCR_CW-1:0]                    sense;
		logic                                  sense_v;
		logic [`CCR_CW-1:0]                    low_q;
		logic                                  low_v;
		logic [`CCR_CW-1:0]                    mult_q;
		logic                                  mult_v;
	} ccr_state_t;

endpackage

`default_nettype wire

// File: hdl/ccr_sync.sv
// Two-stage synchroniser for the gate clock and path switch pins.
`include "ccr_cfg.svh"
`default_nettype none

module ccr_sync
(
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	input  wire logic [`CCR_NSYNC-1:0] pins_i,
	output var  logic [`CCR_NSYNC-1:0] sync_o
);

	ccr_pkg::ccr_sync_t st;
	ccr_pkg::ccr_sync_t next_st;

	always_comb
	begin
		next_st.s1 = pins_i;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	for (genvar i = 0; i < `CCR_NSYNC; i++)
	begin : g_out
		assign sync_o[i] = st.s2[i];
	end

endmodule

`default_nettype wire

// File: test/ccr_tgen.sv
// Generator model: gate clocks and per-packet routing.
`include "ccr_cfg.svh"
`default_nettype none
module ccr_tgen
(
	input  wire logic               clk_i,
	input  wire logic [`CCR_CW-1:0] sense_i,
	input  wire logic               sense_valid_i,
	output var  logic               top_o,
	output var  logic               bot_o,
	output var  logic               row_o,
	output var  logic               last_o,
	output var  logic               nsw_o,
	output var  logic               msw_o,
	output var  int                 fc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [`CCR_CW-1:0] LIMIT = 16'h0096;
	logic [31:0] dec = '0;
	logic        shutter = 1'b0;
	logic        fg_exit = 1'b0;
	logic        fg_reset = 1'b0;
	initial
	begin
		{top_o, bot_o, row_o, last_o, nsw_o, msw_o} = '0;
		fc_o = 0;
	end
	always @(posedge clk_i)
		if (sense_valid_i === 1'b1)
			dec[fc_o % 32] <= sense_i <= LIMIT;
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic clear();
		{last_o, nsw_o, msw_o} = '0;
		shutter = 1'b1;
		step(200);
		shutter = 1'b0;
		step(4);
	endtask
	task automatic transfer();
		{top_o, bot_o} = 2'h3;
		step(500);
		{top_o, bot_o} = 2'h0;
		step(4);
	endtask
	task automatic row_load();
		row_o = 1'b1;
		step(8);
		row_o = 1'b0;
		fc_o = 0;
		step(4);
	endtask
	task automatic line();
		for (int m = 1; m <= 3084; m++)
		begin
			if (m > 28)
			begin
				msw_o = dec[(m - 28) % 32];
				nsw_o = !msw_o;
			end
			last_o = 1'b1;
			step(5);
			{last_o, nsw_o, msw_o} = '0;
			fc_o = m;
			step(1);
			{fg_exit, fg_reset} = 2'h3;
			step(3);
			{fg_exit, fg_reset} = 2'h0;
			step(1);
		end
	endtask
endmodule
`default_nettype wire

// File: test/ccr_quadrant_tb_top.sv
// Bench: one quadrant read out by the generator model.
`include "ccr_cfg.svh"
`default_nettype none
module ccr_quadrant_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                               clk = 1'b0;
	logic                               srst = 1'b1;
	logic                               top, bot, row, last, nsw, msw;
	logic [`CCR_NCOLS-1:0][`CCR_CW-1:0] pd = '0;
	ccr_pkg::ccr_charge_t               col [`CCR_NCOLS];
	ccr_pkg::ccr_charge_t               so, lo, mo;
	logic                               sv, lv, mv;
	int                                 fc;
	int                                 fail_count = 0;
	int                                 checks_done = 0;
	int                                 n_low = 0;
	int                                 n_mult = 0;
	always #2.5 clk = ~clk;
	ccr_tgen u_ccr_tgen (.clk_i(clk), .sense_i(so), .sense_valid_i(sv),
		.top_o(top), .bot_o(bot), .row_o(row), .last_o(last),
		.nsw_o(nsw), .msw_o(msw), .fc_o(fc));
	ccr_quadrant u_ccr_quadrant (.clk_i(clk), .srst_i(srst),
		.vertical_phase1_top_i(top), .vertical_phase1_bottom_i(bot),
		.row_transfer_i(row), .horiz_last_gate_i(last),
		.normal_path_switch_i(nsw), .multiplier_path_switch_i(msw),
		.photodiode_charge_i(pd), .threshold_sense_output_o(so),
		.sense_valid_o(sv), .low_gain_output_o(lo),
		.low_gain_valid_o(lv), .multiplier_output_o(mo),
		.multiplier_valid_o(mv));
	function automatic ccr_pkg::ccr_charge_t exp_at(input int k);
		if (k >= 36 && k < 36 + `CCR_NCOLS)
			return col[k - 36];
		return '0;
	endfunction
	task automatic check(input string what, input ccr_pkg::ccr_charge_t seen,
		input ccr_pkg::ccr_charge_t want);
		checks_done++;
		if (seen !== want)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		if (sv === 1'b1)
			check("sense", so, exp_at(fc));
		if (lv === 1'b1)
		begin
			n_low++;
			check("low", lo, exp_at(fc - 28));
		end
		if (mv === 1'b1)
		begin
			n_mult++;
			check("mult", mo, exp_at(fc - 28));
		end
	end
	initial
	begin
		int                                 seed;
		int                                 big;
		logic [`CCR_CW:0]                   s;
		logic [`CCR_NCOLS-1:0][`CCR_CW-1:0] pa, pb;
		seed = $urandom(32'h578805d7);
		for (int it = 0; it < 2; it++)
		begin
			srst = 1'b1;
			repeat (20) @(posedge clk);
			check("reset low", lo, '0);
			check("reset mult", mo, '0);
			check("reset sense", so, '0);
			#1 srst = 1'b0;
			big = 0;
			n_low = 0;
			n_mult = 0;
			for (int j = 0; j < `CCR_NCOLS; j++)
			begin
				pa[j] = 16'($urandom_range(300));
				pb[j] = 16'($urandom_range(300));
			end
			if (it == 0)
			begin
				pa[0] = 16'h0064;
				pb[0] = 16'h0032;
				pa[1] = 16'h0097;
				pb[1] = 16'h0000;
				pa[7] = 16'hFFF0;
				pb[7] = 16'h0020;
			end
			for (int j = 0; j < `CCR_NCOLS; j++)
			begin
				s = pa[j] + pb[j];
				col[j] = s[16] ? 16'hFFFF : s[15:0];
				big += int'(col[j] > 16'h0096);
			end
			u_ccr_tgen.clear();
			pd = pa;
			u_ccr_tgen.transfer();
			pd = pb;
			u_ccr_tgen.transfer();
			u_ccr_tgen.row_load();
			u_ccr_tgen.line();
			check("low count", 16'(n_low), 16'(big));
			check("mult count", 16'(n_mult), 16'(3056 - big));
		end
		complete_run();
	end
endmodule
`default_nettype wire
